// File: verilog/psr_top.sv
// psr_top: eight-stage parallel-load shift register with serial output.
// assumes: all pin inputs are asynchronous to clk; the drain of the
// shifted-out bit stream runs on clk.
//
// Overview of operation
// - exactly eight stages in one chain
// - select low loads each stage from data
// - load overrides clock, gate and chain bit
// - select high: no load, hold unless shifting
// - clock rises with gate low: shift once
// - gate rises with clock low: shift too
// - each stage after the first takes its predecessor on shift
// - first stage captures chain bit on shift
// - inverted output mirrors last stage once it is defined
// - stages have no reset or start value
`timescale 1ns/1ps
`include "psr_defs.svh"
module psr_top
(
    input wire logic clk, // system clock, 40 MHz
    input wire logic rst, // async reset, high
    input wire logic shift_or_load_select, // pin: low loads, high shifts
    input wire logic shift_clock_input, // pin: shift clock
    input wire logic clock_gate_input, // pin: clock gate
    input wire logic chain_input_bit, // pin: serial chain input
    input wire logic [`PSR_LAST:0] parallel_data_in, // pins: one per stage
    output logic last_stage_out, // last stage level
    output logic last_stage_out_inverted, // inverse of last stage
    output psr_pkg::psr_word_type stage_word_out, // all stages, bit 7 last
    output logic contents_defined, // every stage loaded or filled
    output logic [`PSR_CNT_W-1:0] shift_count_out, // shifts since load, saturating
    output psr_pkg::psr_mode_type mode_out, // operation of the last cycle
    output logic shift_stalled, // a shift waits for buffer room
    output logic shift_overrun, // a shift edge was dropped
    output logic shifted_bit_valid, // stream: bit leaving the chain
    input wire logic shifted_bit_ready, // stream: drain accepts
    output logic shifted_bit_data // stream: bit value
);
    import psr_pkg::*;

    // synchronised pins
    logic [`PSR_PIN_W-1:0] pin_sync;

    // chain and its bookkeeping
    psr_word_type stage_ff;
    psr_word_type defined_ff;
    psr_word_type nxt_stage;
    psr_word_type nxt_defined;
    psr_word_type shift_src;
    psr_word_type defined_src;

    // edge detection and stall
    logic prev_clock_ff;
    logic pending_ff;
    logic overrun_ff;

    // registered outputs
    logic last_ff;
    logic last_inv_ff;
    logic all_defined_ff;
    logic [`PSR_CNT_W-1:0] count_ff;
    psr_mode_type mode_ff;

    // buffer side
    logic buf_in_ready;

    wire logic [`PSR_PIN_W-1:0] pin_raw =
    {
        shift_or_load_select,
        shift_clock_input,
        clock_gate_input,
        chain_input_bit,
        parallel_data_in
    };

    psr_sync #(
        .WIDTH(`PSR_PIN_W),
        .RST_VAL(`PSR_PIN_RST)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .d_in(pin_raw),
        .q_out(pin_sync)
    );

    wire logic select_s = pin_sync[`PSR_PIN_SEL];
    wire logic clock_s = pin_sync[`PSR_PIN_CLK];
    wire logic gate_s = pin_sync[`PSR_PIN_GATE];
    wire logic chain_s = pin_sync[`PSR_PIN_SER];
    wire psr_word_type data_s = pin_sync[`PSR_PIN_DATA_HI:0];

    wire logic load_active = ~select_s;

    wire logic combined_clock = clock_s | gate_s;

    // rising edge while the other input is low
    wire logic clock_rise = combined_clock & ~prev_clock_ff;

    wire logic shift_request = select_s & (clock_rise | pending_ff);

    // a shift waits while the buffer has no room
    wire logic do_shift = shift_request & buf_in_ready;
    wire logic stall_now = shift_request & ~buf_in_ready;

    wire logic nxt_pending = stall_now & ~load_active;

    // edge arriving while one already waits is dropped
    wire logic overrun_set = pending_ff & clock_rise & stall_now;
    wire logic nxt_overrun = overrun_set | (overrun_ff & ~load_active);

    genvar i;
    generate
        for (i = 0; i < `PSR_STAGES; i = i + 1)
        begin : g_stage
            if (i == 0)
            begin : g_first
                // first stage takes the chain bit
                assign shift_src[i] = chain_s;
                assign defined_src[i] = 1'b1;
            end
            else
            begin : g_rest
                // predecessor moves toward the last stage
                assign shift_src[i] = stage_ff[i-1];
                assign defined_src[i] = defined_ff[i-1];
            end

            assign nxt_stage[i] = load_active ? data_s[i] :
                                  do_shift ? shift_src[i] : stage_ff[i];
            assign nxt_defined[i] = load_active ? 1'b1 :
                                    do_shift ? defined_src[i] : defined_ff[i];
        end
    endgenerate

    wire logic count_step = do_shift & (count_ff != `PSR_CNT_FULL);
    wire logic [`PSR_CNT_W-1:0] nxt_count = load_active ? `PSR_CNT_ZERO :
                                           count_step ? count_ff + `PSR_CNT_ONE : count_ff;

    wire psr_mode_type nxt_mode = load_active ? PSR_LOAD :
                                  do_shift ? PSR_SHIFT :
                                  stall_now ? PSR_STALL : PSR_HOLD;

    always_ff @(posedge clk)
    begin
        stage_ff <= nxt_stage;
    end

    // tracks which stages hold a known value since reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            defined_ff <= `PSR_MASK_NONE;
        else
            defined_ff <= nxt_defined;
    end

    // reset high so a pin already high gives no false edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prev_clock_ff <= 1'b1;
            pending_ff <= 1'b0;
            overrun_ff <= 1'b0;
        end
        else
        begin
            prev_clock_ff <= combined_clock;
            pending_ff <= nxt_pending;
            overrun_ff <= nxt_overrun;
        end
    end

    // unknown last stage keeps the pins at their reset levels
    wire logic nxt_last = nxt_defined[`PSR_LAST] ? nxt_stage[`PSR_LAST] : last_ff;

    // true and inverted outputs from one source
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            last_ff <= `PSR_OUT_RST;
            last_inv_ff <= `PSR_OUTN_RST;
        end
        else
        begin
            last_ff <= nxt_last;
            last_inv_ff <= ~nxt_last;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            all_defined_ff <= 1'b0;
            count_ff <= `PSR_CNT_ZERO;
            mode_ff <= PSR_HOLD;
        end
        else
        begin
            all_defined_ff <= (nxt_defined == `PSR_MASK_ALL);
            count_ff <= nxt_count;
            mode_ff <= nxt_mode;
        end
    end

    // bit leaving the last stage, kept until the drain takes it
    psr_buf #(
        .WIDTH(`PSR_BUF_W)
    ) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(do_shift),
        .in_ready(buf_in_ready),
        .in_data(stage_ff[`PSR_LAST]),
        .out_valid(shifted_bit_valid),
        .out_ready(shifted_bit_ready),
        .out_data(shifted_bit_data)
    );

    assign last_stage_out = last_ff;
    assign last_stage_out_inverted = last_inv_ff;
    assign stage_word_out = stage_ff;
    assign contents_defined = all_defined_ff;
    assign shift_count_out = count_ff;
    assign mode_out = mode_ff;
    assign shift_stalled = pending_ff;
    assign shift_overrun = overrun_ff;
endmodule

// File: verilog/psr_defs.svh
// psr_defs.svh: sizes, pin positions, reset values and timing figures
// of the parallel-load shift register block.
// assumes: included by psr_pkg and by every design file that needs them.
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH

// chain geometry
`define PSR_STAGES 8
`define PSR_LAST 7

// packed pin vector: select, clock, gate, chain bit, parallel data
`define PSR_PIN_W 12
`define PSR_PIN_SEL 11
`define PSR_PIN_CLK 10
`define PSR_PIN_GATE 9
`define PSR_PIN_SER 8
`define PSR_PIN_DATA_HI 7

// synchroniser reset: select, clock and gate high, the rest low
`define PSR_PIN_RST 12'hE00

// shift counter since the last load
`define PSR_CNT_W 4
`define PSR_CNT_ZERO 4'h0
`define PSR_CNT_ONE 4'h1
`define PSR_CNT_FULL 4'h8

// output reset values
`define PSR_OUT_RST 1'b0
`define PSR_OUTN_RST 1'b1
`define PSR_MASK_NONE 8'h00
`define PSR_MASK_ALL 8'hFF

// buffer of shifted-out bits
`define PSR_BUF_W 1

// system clock period
`define PSR_CLK_PERIOD_NS 25

`endif

// File: verilog/psr_pkg.sv
// psr_pkg: types shared by the shift register block.
// assumes: psr_defs.svh is on the include path.
package psr_pkg;
    `include "psr_defs.svh"

    // gray-coded along hold -> shift -> load, stall off the main path
    typedef enum logic [1:0]
    {
        PSR_HOLD = 2'h0,
        PSR_SHIFT = 2'h1,
        PSR_LOAD = 2'h3,
        PSR_STALL = 2'h2
    } psr_mode_type;

    typedef logic [`PSR_STAGES-1:0] psr_word_type;
endpackage

// File: verilog/psr_sync.sv
// psr_sync: two-flop synchroniser, one per bit, for the pin inputs.
// assumes: inputs are asynchronous to clk; reset value per bit given.
`timescale 1ns/1ps
module psr_sync
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic [WIDTH-1:0] d_in, // raw pin levels
    output logic [WIDTH-1:0] q_out // synchronised levels
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            always_ff @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    meta_ff[i] <= RST_VAL[i];
                    sync_ff[i] <= RST_VAL[i];
                end
                else
                begin
                    meta_ff[i] <= d_in[i];
                    sync_ff[i] <= meta_ff[i];
                end
            end
        end
    endgenerate

    assign q_out = sync_ff;
endmodule

// File: verilog/psr_buf.sv
// psr_buf: two-entry buffer with valid/ready on both sides.
// assumes: one clock; head entry drives the outputs from flops.
`timescale 1ns/1ps
module psr_buf
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk, // system clock
    input wire logic rst, // async reset, high
    input wire logic in_valid, // word offered
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // offered word
    output logic out_valid, // head word present
    input wire logic out_ready, // drain accepts head
    output logic [WIDTH-1:0] out_data // head word
);
    logic head_valid_ff;
    logic spare_valid_ff;
    logic [WIDTH-1:0] head_ff;
    logic [WIDTH-1:0] spare_ff;

    wire logic push = in_valid & ~spare_valid_ff;
    wire logic pop = head_valid_ff & out_ready;
    wire logic head_from_spare = pop & spare_valid_ff;
    wire logic head_from_in = push & (pop ? ~spare_valid_ff : ~head_valid_ff);
    wire logic spare_from_in = push & ~head_from_in & ~(pop & ~spare_valid_ff);

    wire logic nxt_head_valid = head_valid_ff ? (~pop | spare_valid_ff | push) : push;
    wire logic nxt_spare_valid = spare_from_in | (spare_valid_ff & ~pop);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            head_valid_ff <= 1'b0;
            spare_valid_ff <= 1'b0;
        end
        else
        begin
            head_valid_ff <= nxt_head_valid;
            spare_valid_ff <= nxt_spare_valid;
        end
    end

    // data words carry no reset
    always_ff @(posedge clk)
    begin
        if (head_from_spare)
            head_ff <= spare_ff;
        else if (head_from_in)
            head_ff <= in_data;
        if (spare_from_in)
            spare_ff <= in_data;
    end

    assign in_ready = ~spare_valid_ff;
    assign out_valid = head_valid_ff;
    assign out_data = head_ff;
endmodule

// File: verif/psr_top_assertions.sv
// psr_top_assertions: port checker for psr_top.
// assumes: bound into psr_top; one clock, async high reset.
`timescale 1ns/1ps
`include "psr_defs.svh"
module psr_top_assertions
(
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic shift_or_load_select, // load pin
    input wire logic shift_clock_input, // clock pin
    input wire logic clock_gate_input, // gate pin
    input wire logic chain_input_bit, // chain pin
    input wire logic [`PSR_LAST:0] parallel_data_in, // data pins
    input wire logic last_stage_out, // last stage
    input wire logic last_stage_out_inverted, // inverse
    input wire psr_pkg::psr_word_type stage_word_out, // stages
    input wire logic contents_defined, // known data
    input wire logic [`PSR_CNT_W-1:0] shift_count_out, // shift count
    input wire psr_pkg::psr_mode_type mode_out, // last operation
    input wire logic shift_stalled, // waiting shift
    input wire logic shift_overrun, // lost edge
    input wire logic shifted_bit_valid, // stream valid
    input wire logic shifted_bit_ready, // stream ready
    input wire logic shifted_bit_data // stream bit
);
    import psr_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_load_steady;
        (!shift_or_load_select && $stable(parallel_data_in))[*4];
    endsequence
    sequence s_quiet;
        (shift_or_load_select && shift_clock_input && clock_gate_input && !shift_stalled && contents_defined)[*5];
    endsequence
    sequence s_shifted;
        mode_out == PSR_SHIFT;
    endsequence
    AST_LOAD_TAKEN: assert property (s_load_steady |-> stage_word_out == parallel_data_in &&
        mode_out == PSR_LOAD && shift_count_out == `PSR_CNT_ZERO) else $error("load not taken");
    AST_HOLD_QUIET: assert property (s_quiet |-> $stable(stage_word_out))
        else $error("stages moved without an edge");
    AST_CHAIN_MOVE: assert property (s_shifted ##0 $past(contents_defined) |->
        stage_word_out[7:1] == $past(stage_word_out[6:0])) else $error("chain did not move");
    AST_CHAIN_IN: assert property (s_shifted |-> stage_word_out[0] == $past(chain_input_bit, 3))
        else $error("chain bit not captured");
    AST_LAST_MATCH: assert property (contents_defined |-> last_stage_out == stage_word_out[`PSR_LAST])
        else $error("last output differs from stage");
    AST_INVERSE: assert property (last_stage_out_inverted == !last_stage_out)
        else $error("inverse output wrong");
    AST_COUNT_STEP: assert property (s_shifted |-> shift_count_out == (($past(shift_count_out) ==
        `PSR_CNT_FULL) ? `PSR_CNT_FULL : $past(shift_count_out) + `PSR_CNT_ONE)) else $error("count wrong");
    AST_EMIT_OLD: assert property (s_shifted ##0 !$past(shifted_bit_valid) |->
        shifted_bit_valid && shifted_bit_data == $past(last_stage_out)) else $error("wrong bit emitted");
    AST_STREAM_HOLD: assert property (shifted_bit_valid && !shifted_bit_ready |=>
        shifted_bit_valid && $stable(shifted_bit_data)) else $error("stream bit dropped");
endmodule

bind psr_top psr_top_assertions u_psr_top_assertions (.clk, .rst, .shift_or_load_select, .shift_clock_input,
    .clock_gate_input, .chain_input_bit, .parallel_data_in, .last_stage_out, .last_stage_out_inverted,
    .stage_word_out, .contents_defined, .shift_count_out, .mode_out, .shift_stalled, .shift_overrun,
    .shifted_bit_valid, .shifted_bit_ready, .shifted_bit_data);

// File: verif/psr_host_model.sv
// psr_host_model: host driving load, clock, gate, chain and data pins.
// assumes: pins move 1 ns after a clk rise; each level stands at least HOLD_CYC clocks.
`timescale 1ns/1ps
module psr_host_model
#(
    parameter int HOLD_CYC = 4
)
(
    input wire logic clk, // system clock
    output logic shift_or_load_select, // low loads
    output logic shift_clock_input, // clock pin
    output logic clock_gate_input, // gate pin
    output logic chain_input_bit, // chain pin
    output psr_pkg::psr_word_type parallel_data_in // data pins
);
    import psr_pkg::*;
    initial
    begin
        shift_or_load_select = 1'b1;
        shift_clock_input = 1'b0;
        clock_gate_input = 1'b0;
        chain_input_bit = 1'b0;
        parallel_data_in = 8'h00;
    end
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic load(input psr_word_type d);
        parallel_data_in = d;
        shift_or_load_select = 1'b0;
        settle(HOLD_CYC);
        shift_or_load_select = 1'b1;
        settle(1);
        parallel_data_in = ~d;
        settle(HOLD_CYC);
    endtask
    task automatic shift(input logic b, input logic via_gate);
        chain_input_bit = b;
        settle(HOLD_CYC);
        if (via_gate)
            clock_gate_input = 1'b1;
        else
            shift_clock_input = 1'b1;
        settle(HOLD_CYC);
        clock_gate_input = 1'b0;
        shift_clock_input = 1'b0;
        settle(HOLD_CYC);
    endtask
    task automatic held_toggle();
        shift_clock_input = 1'b1;
        settle(HOLD_CYC);
        clock_gate_input = 1'b1;
        settle(6);
        repeat (2)
        begin
            shift_clock_input = 1'b0;
            settle(HOLD_CYC);
            shift_clock_input = 1'b1;
            settle(HOLD_CYC);
        end
        clock_gate_input = 1'b0;
        settle(HOLD_CYC);
        shift_clock_input = 1'b0;
        settle(HOLD_CYC);
    endtask
endmodule

// File: verif/psr_top_test.sv
// psr_top_test: self-checking bench for psr_top.
// assumes: psr_host_model drives the pins; the bench drives reset and drain.
`timescale 1ns/1ps
module psr_top_test;
    import psr_pkg::*;
    typedef struct {psr_word_type data; logic last;} psr_row_type;
    psr_row_type rows [6] = '{'{8'h00, 1'b0}, '{8'hFF, 1'b1}, '{8'hA5, 1'b1}, '{8'h5A, 1'b0},
        '{8'h80, 1'b1}, '{8'h7F, 1'b0}};
    logic clk, rst, shifted_bit_ready, shift_or_load_select, shift_clock_input, clock_gate_input;
    logic chain_input_bit, last_stage_out, last_stage_out_inverted, contents_defined, shift_stalled;
    logic shift_overrun, shifted_bit_valid, shifted_bit_data;
    logic [3:0] shift_count_out;
    psr_word_type parallel_data_in, stage_word_out, exp_word;
    psr_mode_type mode_out;
    logic exp_q [$];
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    psr_host_model u_psr_host_model (.clk, .shift_or_load_select, .shift_clock_input, .clock_gate_input,
        .chain_input_bit, .parallel_data_in);
    psr_top u_psr_top (.clk, .rst, .shift_or_load_select, .shift_clock_input, .clock_gate_input,
        .chain_input_bit, .parallel_data_in, .last_stage_out, .last_stage_out_inverted, .stage_word_out,
        .contents_defined, .shift_count_out, .mode_out, .shift_stalled, .shift_overrun,
        .shifted_bit_valid, .shifted_bit_ready, .shifted_bit_data);
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic push(input logic b, input logic via_gate);
        exp_q.push_back(exp_word[7]);
        exp_word = {exp_word[6:0], b};
        u_psr_host_model.shift(b, via_gate);
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (!rst && shifted_bit_valid === 1'b1 && shifted_bit_ready === 1'b1)
            check("stream bit", {7'h00, exp_q.pop_front()}, {7'h00, shifted_bit_data});
        if (cycles == 20000)
        begin
            n_fail++;
            conclude();
        end
    end
    initial
    begin
        rst = 1'b1;
        shifted_bit_ready = 1'b1;
        wait_clk(16);
        rst = 1'b0;
        check("defined", 8'h00, {7'h00, contents_defined});
        foreach (rows[i])
        begin
            u_psr_host_model.load(rows[i].data);
            check("word", rows[i].data, stage_word_out);
            check("last", {7'h00, rows[i].last}, {7'h00, last_stage_out});
            check("inverse", {7'h00, ~rows[i].last}, {7'h00, last_stage_out_inverted});
            check("count", 8'h00, {4'h0, shift_count_out});
            check("loaded defined", 8'h01, {7'h00, contents_defined});
        end
        exp_word = 8'h7F;
        for (int i = 0; i < 9; i++)
            push(i[0], i[1]);
        check("shifted", exp_word, stage_word_out);
        check("saturate", 8'h08, {4'h0, shift_count_out});
        exp_q.push_back(exp_word[7]);
        exp_word = {exp_word[6:0], 1'b0};
        u_psr_host_model.held_toggle();
        check("one shift", exp_word, stage_word_out);
        shifted_bit_ready = 1'b0;
        u_psr_host_model.load(8'hC3);
        exp_word = 8'hC3;
        for (int i = 0; i < 3; i++)
            push(1'b0, 1'b0);
        check("stalled", 8'h01, {7'h00, shift_stalled});
        check("stall mode", {6'h00, PSR_STALL}, {6'h00, mode_out});
        u_psr_host_model.shift(1'b0, 1'b0);
        check("overrun", 8'h01, {7'h00, shift_overrun});
        shifted_bit_ready = 1'b1;
        wait_clk(6);
        check("after stall", exp_word, stage_word_out);
        check("drained", 8'h00, {7'h00, shifted_bit_valid});
        check("queue left", 8'h00, 8'(exp_q.size()));
        u_psr_host_model.load(8'h3C);
        check("overrun clear", 8'h00, {7'h00, shift_overrun});
        rst = 1'b1;
        wait_clk(2);
        check("reset last", 8'h00, {7'h00, last_stage_out});
        check("reset inverse", 8'h01, {7'h00, last_stage_out_inverted});
        check("reset defined", 8'h00, {7'h00, contents_defined});
        rst = 1'b0;
        u_psr_host_model.load(8'h96);
        check("reload", 8'h96, stage_word_out);
        conclude();
    end
endmodule
